// *** fv_fader.sv ***
`timescale 1ns/10ps
// Colour-key fader with its serial control port
module fv_fader #(
  parameter logic [6:0] DEV_ADDR = fv_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SAMPLE_VALID,
  input wire fv_pkg::fv_ycc_t MAIN_IN,
  input wire fv_pkg::fv_ycc_t VIDEO_IN,
  output logic OUT_VALID,
  output fv_pkg::fv_ycc_t FADER_OUT,
  output fv_pkg::fv_ycc_t ENC_OUT
);

  // Pin synchronisers; stage 3 only remembers the previous level
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // Serial port state
  fv_pkg::fv_state_t state, next_state;
  logic [3:0] cnt, next_cnt; // Bit counter
  logic [7:0] shreg, next_shreg; // Shift register
  logic [7:0] sub, next_sub; // Current subaddress
  logic got_addr, next_got_addr; // Device address taken
  logic got_sub, next_got_sub; // Subaddress taken
  logic rw, next_rw; // Transfer is a read
  logic nack, next_nack; // Master refused more data
  logic wr_en; // Write strobe into the register file
  logic [7:0] wr_data; // Byte being written

  // Register file
  fv_pkg::fv_cfg_t cfg, next_cfg;

  // Datapath
  logic key1_hit, key2_hit;
  fv_pkg::fv_ycc_t op_base, op_over, mixed;
  logic [5:0] op_factor;
  fv_pkg::fv_ycc_t next_fader, next_enc;

  // Read value of any subaddress; unmapped and reserved bits read zero
  function automatic logic [7:0] read_reg(input fv_pkg::fv_cfg_t c,
                                          input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      fv_pkg::KEY1_LO_U: r = c.key1_lo.u;
      fv_pkg::KEY1_LO_V: r = c.key1_lo.v;
      fv_pkg::KEY1_LO_Y: r = c.key1_lo.y;
      fv_pkg::KEY2_LO_U: r = c.key2_lo.u;
      fv_pkg::KEY2_LO_V: r = c.key2_lo.v;
      fv_pkg::KEY2_LO_Y: r = c.key2_lo.y;
      fv_pkg::KEY1_HI_U: r = c.key1_hi.u;
      fv_pkg::KEY1_HI_V: r = c.key1_hi.v;
      fv_pkg::KEY1_HI_Y: r = c.key1_hi.y;
      fv_pkg::KEY2_HI_U: r = c.key2_hi.u;
      fv_pkg::KEY2_HI_V: r = c.key2_hi.v;
      fv_pkg::KEY2_HI_Y: r = c.key2_hi.y;
      fv_pkg::FIRST_FADE_FACTOR_ADDR: r = {2'h0, c.first_fade_factor};
      fv_pkg::OVR_SECOND_FADE_FACTOR_ADDR: r = {c.vid_ovr, c.main_ovr, c.second_fade_factor};
      fv_pkg::THIRD_FADE_FACTOR_ADDR: r = {2'h0, c.third_fade_factor};
      fv_pkg::LUT_U_ADDR: r = c.lut.u;
      fv_pkg::LUT_V_ADDR: r = c.lut.v;
      fv_pkg::LUT_Y_ADDR: r = c.lut.y;
      fv_pkg::PATH_SEL_ADDR: r = {2'h0, c.enc_sel, 5'h00};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Two-flop synchronisers plus one history stage for edge detection
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= SCL;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= SDA_IN;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // Bus events seen on the synchronised lines
  always_comb begin
    scl_rise = scl_s2 & ~scl_s3;
    scl_fall = ~scl_s2 & scl_s3;
    start_seen = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    stop_seen = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
  end

  // Serial slave: address, subaddress, then auto-incremented data
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_sub = sub;
    next_got_addr = got_addr;
    next_got_sub = got_sub;
    next_rw = rw;
    next_nack = nack;
    wr_en = 1'b0;
    wr_data = shreg;
    if (start_seen) begin
      // Start or repeated start restarts addressing
      next_state = fv_pkg::FV_RX;
      next_cnt = 4'h0;
      next_got_addr = 1'b0;
    end else if (stop_seen) begin
      next_state = fv_pkg::FV_IDLE;
    end else begin
      unique case (state)
        fv_pkg::FV_IDLE: begin
          next_cnt = 4'h0;
        end
        fv_pkg::FV_RX: begin
          if (scl_rise && cnt != fv_pkg::BITS_FULL) begin
            // Sample one bit, MSB first
            next_shreg = {shreg[6:0], sda_s2};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == fv_pkg::BITS_FULL) begin
            next_state = fv_pkg::FV_ACKO;
            if (!got_addr) begin
              // Address byte: answer only our own address
              next_got_addr = 1'b1;
              next_rw = shreg[0];
              if (shreg[0] == 1'b0) begin
                next_got_sub = 1'b0;
              end
              if (shreg[7:1] != DEV_ADDR) begin
                next_state = fv_pkg::FV_IDLE;
              end
            end else if (!got_sub) begin
              // Subaddress byte
              next_sub = shreg;
              next_got_sub = 1'b1;
            end else begin
              // Data byte: store and step the subaddress
              wr_en = 1'b1;
              next_sub = sub + 8'h01;
            end
          end
        end
        fv_pkg::FV_ACKO: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              // First read byte comes from the current subaddress
              next_state = fv_pkg::FV_TX;
              next_shreg = read_reg(cfg, sub);
              next_sub = sub + 8'h01;
            end else begin
              next_state = fv_pkg::FV_RX;
            end
          end
        end
        fv_pkg::FV_TX: begin
          if (scl_fall) begin
            if (cnt == fv_pkg::BITS_LAST) begin
              next_state = fv_pkg::FV_ACKI;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_cnt = cnt + 4'h1;
            end
          end
        end
        fv_pkg::FV_ACKI: begin
          if (scl_rise) begin
            next_nack = sda_s2;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (nack) begin
              // Master ends the read
              next_state = fv_pkg::FV_IDLE;
            end else begin
              next_state = fv_pkg::FV_TX;
              next_shreg = read_reg(cfg, sub);
              next_sub = sub + 8'h01;
            end
          end
        end
        default: begin
          next_state = fv_pkg::FV_IDLE;
        end
      endcase
    end
  end

  // Serial slave registers
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= fv_pkg::FV_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      sub <= 8'h00;
      got_addr <= 1'b0;
      got_sub <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      sub <= next_sub;
      got_addr <= next_got_addr;
      got_sub <= next_got_sub;
      rw <= next_rw;
      nack <= next_nack;
    end
  end

  // Open-drain data line: pull low for our acknowledge or a zero bit
  always_comb begin
    SDA_OUT = 1'b0;
    SDA_OE = (state == fv_pkg::FV_ACKO) ||
             ((state == fv_pkg::FV_TX) && !shreg[7]);
  end

  // Register writes; reserved fade bits are dropped
  always_comb begin
    next_cfg = cfg;
    if (wr_en) begin
      case (sub)
        fv_pkg::KEY1_LO_U: next_cfg.key1_lo.u = wr_data;
        fv_pkg::KEY1_LO_V: next_cfg.key1_lo.v = wr_data;
        fv_pkg::KEY1_LO_Y: next_cfg.key1_lo.y = wr_data;
        fv_pkg::KEY2_LO_U: next_cfg.key2_lo.u = wr_data;
        fv_pkg::KEY2_LO_V: next_cfg.key2_lo.v = wr_data;
        fv_pkg::KEY2_LO_Y: next_cfg.key2_lo.y = wr_data;
        fv_pkg::KEY1_HI_U: next_cfg.key1_hi.u = wr_data;
        fv_pkg::KEY1_HI_V: next_cfg.key1_hi.v = wr_data;
        fv_pkg::KEY1_HI_Y: next_cfg.key1_hi.y = wr_data;
        fv_pkg::KEY2_HI_U: next_cfg.key2_hi.u = wr_data;
        fv_pkg::KEY2_HI_V: next_cfg.key2_hi.v = wr_data;
        fv_pkg::KEY2_HI_Y: next_cfg.key2_hi.y = wr_data;
        fv_pkg::FIRST_FADE_FACTOR_ADDR: next_cfg.first_fade_factor = wr_data[5:0];
        fv_pkg::OVR_SECOND_FADE_FACTOR_ADDR: begin
          next_cfg.vid_ovr = wr_data[fv_pkg::VID_OVR_BIT];
          next_cfg.main_ovr = wr_data[fv_pkg::MAIN_OVR_BIT];
          next_cfg.second_fade_factor = wr_data[5:0];
        end
        fv_pkg::THIRD_FADE_FACTOR_ADDR: next_cfg.third_fade_factor = wr_data[5:0];
        fv_pkg::LUT_U_ADDR: next_cfg.lut.u = wr_data;
        fv_pkg::LUT_V_ADDR: next_cfg.lut.v = wr_data;
        fv_pkg::LUT_Y_ADDR: next_cfg.lut.y = wr_data;
        fv_pkg::PATH_SEL_ADDR: next_cfg.enc_sel = wr_data[fv_pkg::ENC_SEL_BIT];
        default: next_cfg = cfg;
      endcase
    end
  end

  // Register file; limits, lookup colour at 80h, factors at 3Fh
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cfg <= fv_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Key windows on the main stream
  fv_key_window u_key1 (
    .sample(MAIN_IN), .lower(cfg.key1_lo), .upper(cfg.key1_hi), .hit(key1_hit)
  );
  fv_key_window u_key2 (
    .sample(MAIN_IN), .lower(cfg.key2_lo), .upper(cfg.key2_hi), .hit(key2_hit)
  );

  // Operand choice: overrides, then key 1, then key 2, then default mix
  always_comb begin
    op_base = MAIN_IN;
    op_over = VIDEO_IN;
    op_factor = cfg.third_fade_factor;
    if (cfg.vid_ovr) begin
      // Whole video stream against lookup colour, keys ignored
      op_base = cfg.lut;
      op_over = VIDEO_IN;
      op_factor = cfg.second_fade_factor;
    end else if (cfg.main_ovr) begin
      // Whole main stream against lookup colour, keys ignored
      op_base = cfg.lut;
      op_over = MAIN_IN;
      op_factor = cfg.second_fade_factor;
    end else if (key1_hit) begin
      // Key 1 takes precedence over key 2
      op_factor = cfg.first_fade_factor;
    end else if (key2_hit) begin
      // Video against inserted lookup colour
      op_base = cfg.lut;
      op_factor = cfg.second_fade_factor;
    end
  end

  // One blender per component
  fv_blend u_blend_y (
    .base(op_base.y), .over(op_over.y), .factor(op_factor), .mixed(mixed.y)
  );
  fv_blend u_blend_u (
    .base(op_base.u), .over(op_over.u), .factor(op_factor), .mixed(mixed.u)
  );
  fv_blend u_blend_v (
    .base(op_base.v), .over(op_over.v), .factor(op_factor), .mixed(mixed.v)
  );

  // Output next values; encoder path bypasses the fader unless selected
  always_comb begin
    next_fader = SAMPLE_VALID ? mixed : FADER_OUT;
    next_enc = ENC_OUT;
    if (SAMPLE_VALID) begin
      next_enc = cfg.enc_sel ? mixed : MAIN_IN;
    end
  end

  // Output registers, one cycle after the sample
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OUT_VALID <= 1'b0;
      FADER_OUT <= fv_pkg::MID_YCC;
      ENC_OUT <= fv_pkg::MID_YCC;
    end else begin
      OUT_VALID <= SAMPLE_VALID;
      FADER_OUT <= next_fader;
      ENC_OUT <= next_enc;
    end
  end

endmodule

// *** fv_pkg.sv ***
// How it works
// - Key 2 hits: U, V, Y within limits
// - Key 2 mixes video with lookup colour
// - All key 2 limit bytes reset to 80h
// - First fade factor weights video on key 1
// - First factor 00h main only, 3Fh video
// - Video override fades video with lookup colour
// - Main override fades main with lookup colour
// - Second factor 00h lookup only, 3Fh video (main stream under main override)
// - No key hit mixes with third factor
// - Lookup U and V reset to 80h
// - Key 1 mixes video with main stream
// - Lookup Y resets to 80h, inserted too
// - Encoder takes fader only when selected
package fv_pkg;

  // One Y/U/V sample
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } fv_ycc_t;

  // Software-visible fader configuration
  typedef struct packed {
    fv_ycc_t key1_lo;
    fv_ycc_t key1_hi;
    fv_ycc_t key2_lo;
    fv_ycc_t key2_hi;
    logic [5:0] first_fade_factor;
    logic [5:0] second_fade_factor;
    logic [5:0] third_fade_factor;
    logic vid_ovr;
    logic main_ovr;
    fv_ycc_t lut;
    logic enc_sel;
  } fv_cfg_t;

  // Serial port states
  typedef enum logic [4:0] {
    FV_IDLE = 5'h01,
    FV_RX = 5'h02,
    FV_ACKO = 5'h04,
    FV_TX = 5'h08,
    FV_ACKI = 5'h10
  } fv_state_t;

  // Register subaddresses
  localparam logic [7:0] KEY1_LO_U = 8'h42;
  localparam logic [7:0] KEY1_LO_V = 8'h43;
  localparam logic [7:0] KEY1_LO_Y = 8'h44;
  localparam logic [7:0] KEY2_LO_U = 8'h45;
  localparam logic [7:0] KEY2_LO_V = 8'h46;
  localparam logic [7:0] KEY2_LO_Y = 8'h47;
  localparam logic [7:0] KEY1_HI_U = 8'h48;
  localparam logic [7:0] KEY1_HI_V = 8'h49;
  localparam logic [7:0] KEY1_HI_Y = 8'h4A;
  localparam logic [7:0] KEY2_HI_U = 8'h4B;
  localparam logic [7:0] KEY2_HI_V = 8'h4C;
  localparam logic [7:0] KEY2_HI_Y = 8'h4D;
  localparam logic [7:0] FIRST_FADE_FACTOR_ADDR = 8'h4E;
  localparam logic [7:0] OVR_SECOND_FADE_FACTOR_ADDR = 8'h4F;
  localparam logic [7:0] THIRD_FADE_FACTOR_ADDR = 8'h50;
  localparam logic [7:0] LUT_U_ADDR = 8'h51;
  localparam logic [7:0] LUT_V_ADDR = 8'h52;
  localparam logic [7:0] LUT_Y_ADDR = 8'h53;
  localparam logic [7:0] PATH_SEL_ADDR = 8'h54;

  // Field positions
  localparam int VID_OVR_BIT = 7;
  localparam int MAIN_OVR_BIT = 6;
  localparam int ENC_SEL_BIT = 5;

  // Reset values and arithmetic constants
  localparam logic [7:0] MID = 8'h80;
  localparam logic [5:0] FADE_MAX = 6'h3F;
  localparam logic [13:0] FADE_DIV = 14'h003F;
  localparam logic [13:0] FADE_ROUND = 14'h001F;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] BITS_FULL = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value
  localparam fv_ycc_t MID_YCC = '{y: MID, u: MID, v: MID};
  localparam fv_cfg_t CFG_RESET = '{key1_lo: MID_YCC, key1_hi: MID_YCC,
    key2_lo: MID_YCC, key2_hi: MID_YCC, first_fade_factor: FADE_MAX, second_fade_factor: FADE_MAX,
    third_fade_factor: FADE_MAX, vid_ovr: 1'b0, main_ovr: 1'b0, lut: MID_YCC,
    enc_sel: 1'b0};

endpackage

// *** fv_key_window.sv ***
`timescale 1ns/10ps
// Tests one sample against a lower/upper colour window
module fv_key_window (
  input wire fv_pkg::fv_ycc_t sample,
  input wire fv_pkg::fv_ycc_t lower,
  input wire fv_pkg::fv_ycc_t upper,
  output logic hit
);

  // Every component must lie inside its own bounds, limits inclusive
  always_comb begin
    hit = (sample.u >= lower.u) && (sample.u <= upper.u) &&
          (sample.v >= lower.v) && (sample.v <= upper.v) &&
          (sample.y >= lower.y) && (sample.y <= upper.y);
  end

endmodule

// *** fv_blend.sv ***
`timescale 1ns/10ps
// Mixes two 8-bit components: factor/63 of over, the rest of base
module fv_blend (
  input wire logic [7:0] base,
  input wire logic [7:0] over,
  input wire logic [5:0] factor,
  output logic [7:0] mixed
);

  logic [5:0] inv; // Weight left for the base operand
  logic [13:0] sum; // Weighted sum, at most 255*63

  // Factor is a fraction of its maximum code, rounded to nearest
  always_comb begin
    inv = fv_pkg::FADE_MAX - factor;
    sum = 14'(over * factor) + 14'(base * inv);
    mixed = 8'((sum + fv_pkg::FADE_ROUND) / fv_pkg::FADE_DIV);
  end

endmodule

// *** fv_fader_checker.sv ***
`timescale 1ns/10ps
// Port-level checks on the sample path and the serial data pin
module fv_fader_checker (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SAMPLE_VALID,
  input wire fv_pkg::fv_ycc_t MAIN_IN,
  input wire logic OUT_VALID,
  input wire fv_pkg::fv_ycc_t FADER_OUT,
  input wire fv_pkg::fv_ycc_t ENC_OUT
);
  // All checks live in the pixel clock domain
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_valid_follows: assert property (SAMPLE_VALID |=> OUT_VALID)
    else $error("valid sample gave no result");
  a_valid_single: assert property (!SAMPLE_VALID |=> !OUT_VALID)
    else $error("result flagged without a sample");
  a_fader_holds: assert property (!SAMPLE_VALID |=> $stable(FADER_OUT))
    else $error("fader output moved without a sample");
  a_enc_holds: assert property (!SAMPLE_VALID |=> $stable(ENC_OUT))
    else $error("encoder output moved without a sample");
  a_enc_source: assert property (SAMPLE_VALID |=>
    (ENC_OUT == $past(MAIN_IN) || ENC_OUT == FADER_OUT))
    else $error("encoder output is neither main nor fader");
  a_reset_outputs: assert property (disable iff (1'b0) SYS_RST |=>
    (!OUT_VALID && !SDA_OE && FADER_OUT == 24'h808080 && ENC_OUT == 24'h808080))
    else $error("outputs wrong after reset");
  a_sda_never_high: assert property (SDA_OUT == 1'b0)
    else $error("serial data driven high");
  a_pull_scl_low: assert property ($rose(SDA_OE) |-> !SCL)
    else $error("serial data pulled while clock high");
endmodule

// *** fv_video_src.sv ***
`timescale 1ns/10ps
// Upstream source of the main stream and the second video stream
module fv_video_src (
  input wire logic clock,
  output logic sample_valid,
  output fv_pkg::fv_ycc_t main_in,
  output fv_pkg::fv_ycc_t video_in
);
  // Idle until the bench asks for a sample
  initial begin
    sample_valid = 1'b0;
    main_in = 24'h000000;
    video_in = 24'h000000;
  end

  // One sample for one cycle, changed at the falling edge
  task automatic send(input fv_pkg::fv_ycc_t m, input fv_pkg::fv_ycc_t v);
    @(negedge clock);
    sample_valid = 1'b1;
    main_in = m;
    video_in = v;
    @(negedge clock);
    // Stale lines show the inverse so no old value can pass for data
    sample_valid = 1'b0;
    main_in = ~m;
    video_in = ~v;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
// Self-checking bench for the colour-key fader
module testbench;
  localparam logic [23:0] VID = 24'h405060; // Fixed second-stream sample
  logic clock;
  logic sys_rst;
  logic scl; // Host serial clock
  logic sda_drv; // Host data, 1 = released
  logic sda_oe;
  logic sda_line; // Open-drain wire with pull-up
  logic sample_valid;
  logic out_valid;
  fv_pkg::fv_ycc_t main_in, video_in, fader_out, enc_out;
  int failures;
  int compares;
  assign sda_line = sda_drv & ~sda_oe;

  fv_video_src u_src (.clock(clock), .sample_valid(sample_valid), .main_in(main_in),
    .video_in(video_in));
  fv_fader u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .SCL(scl), .SDA_IN(sda_line),
    .SDA_OUT(), .SDA_OE(sda_oe), .SAMPLE_VALID(sample_valid), .MAIN_IN(main_in),
    .VIDEO_IN(video_in), .OUT_VALID(out_valid), .FADER_OUT(fader_out), .ENC_OUT(enc_out));

  // Count every comparison and report each mismatch
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Weighted mix of two samples, factor taken out of 63 with rounding
  function automatic logic [23:0] mix(input logic [23:0] b, input logic [23:0] o, input int f);
    logic [23:0] r;
    for (int i = 0; i < 24; i += 8) begin
      r[i+:8] = 8'((o[i+:8] * f + b[i+:8] * (63 - f) + 31) / 63);
    end
    return r;
  endfunction

  // Serial half period: five pixel clocks
  task automatic hp;
    repeat (5) @(negedge clock);
  endtask

  // Start, also used as repeated start
  task automatic start;
    sda_drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl = 1'b0;
    hp;
  endtask

  task automatic stop;
    sda_drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  endtask

  // One byte each way plus acknowledge; data moves one clock after SCL falls
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = tx[i];
      hp;
      scl = 1'b1;
      hp;
      rx = {rx[6:0], sda_line};
      scl = 1'b0;
      @(negedge clock);
    end
    sda_drv = ack_in;
    hp;
    scl = 1'b1;
    hp;
    ack = ~sda_line;
    scl = 1'b0;
    // Host keeps its acknowledge level until the next bit or stop
    @(negedge clock);
  endtask

  // Write n bytes from the top of d, auto-incrementing
  task automatic wrn(input logic [7:0] sub, input logic [23:0] d, input int n);
    logic [7:0] rx;
    logic a;
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
    chk("addr ack", 24'(a), 24'h1);
    xfer(sub, 1'b1, rx, a);
    for (int k = 0; k < n; k++) begin
      xfer(d[23 - 8 * k -: 8], 1'b1, rx, a);
      chk("data ack", 24'(a), 24'h1);
    end
    stop;
  endtask

  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d, a);
    xfer(sub, 1'b1, d, a);
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, d, a);
    xfer(8'hFF, 1'b1, d, a);
    stop;
  endtask

  // Present one sample and judge the fader result
  task automatic smp(input logic [23:0] m, input logic [23:0] e);
    u_src.send(m, VID);
    chk("fader", fader_out, e);
    chk("out valid", 24'(out_valid), 24'h1);
  endtask

  // Reset values, unmapped read, wrong device address, bypass path
  task automatic t_reset;
    logic [7:0] subs[13] = '{8'h45, 8'h46, 8'h47, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F,
      8'h50, 8'h51, 8'h52, 8'h53, 8'h60};
    logic [7:0] exps[13] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h3F, 8'h3F,
      8'h3F, 8'h80, 8'h80, 8'h80, 8'h00};
    logic [7:0] d;
    logic a;
    foreach (subs[i]) begin
      rd(subs[i], d);
      chk("reg", 24'(d), 24'(exps[i]));
    end
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, d, a);
    chk("foreign ack", 24'(a), 24'h0);
    stop;
    smp(24'h102030, VID);
    chk("enc bypass", enc_out, 24'h102030);
  endtask

  // Third factor zero and 21 (one third of 63), then encoder select
  task automatic t_third_fade_factor;
    wrn(8'h50, 24'h000000, 1);
    smp(24'h102030, 24'h102030);
    wrn(8'h50, 24'h150000, 1);
    smp(24'h102030, mix(24'h102030, VID, 21));
    wrn(8'h54, 24'h200000, 1);
    smp(24'h102030, mix(24'h102030, VID, 21));
    chk("enc fader", enc_out, mix(24'h102030, VID, 21));
  endtask

  // Key 2 window edges with lookup colour, second factor sweep
  task automatic t_key2;
    logic [5:0] f2[3] = '{6'h00, 6'h0A, 6'h3F};
    wrn(8'h45, 24'h101010, 3);
    wrn(8'h4B, 24'h202020, 3);
    wrn(8'h51, 24'h304050, 3);
    foreach (f2[i]) begin
      wrn(8'h4F, {2'b00, f2[i], 16'h0000}, 1);
      smp(24'h202020, mix(24'h503040, VID, int'(f2[i])));
      smp(24'h101010, mix(24'h503040, VID, int'(f2[i])));
    end
    smp(24'h212020, mix(24'h212020, VID, 21));
  endtask

  // Two-byte read: host acknowledges the first byte, refuses the second
  task automatic t_burst;
    logic [7:0] d;
    logic a;
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d, a);
    xfer(8'h51, 1'b1, d, a);
    start;
    xfer({fv_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, d, a);
    xfer(8'hFF, 1'b0, d, a);
    chk("burst first", 24'(d), 24'h000030);
    xfer(8'hFF, 1'b1, d, a);
    chk("burst second", 24'(d), 24'h000040);
    stop;
  endtask

  // Key 1 inside key 2: key 1 wins with the first factor
  task automatic t_key1;
    logic [5:0] f1[3] = '{6'h00, 6'h05, 6'h3F};
    wrn(8'h42, 24'h181818, 3);
    wrn(8'h48, 24'h181818, 3);
    foreach (f1[i]) begin
      wrn(8'h4E, {2'b00, f1[i], 16'h0000}, 1);
      smp(24'h181818, mix(24'h181818, VID, int'(f1[i])));
    end
  endtask

  // Overrides disable both keys; video override wins over main
  task automatic t_ovr;
    wrn(8'h4F, 24'h8A0000, 1);
    smp(24'h181818, mix(24'h503040, VID, 10));
    wrn(8'h4F, 24'h4A0000, 1);
    smp(24'h181818, mix(24'h503040, 24'h181818, 10));
    smp(24'h777777, mix(24'h503040, 24'h777777, 10));
    wrn(8'h4F, 24'hCA0000, 1);
    smp(24'h777777, mix(24'h503040, VID, 10));
  endtask

  task automatic give_verdict;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // 25 MHz pixel clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    sys_rst = 1'b1;
    scl = 1'b1;
    sda_drv = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    t_reset;
    t_third_fade_factor;
    t_key2;
    t_burst;
    t_key1;
    t_ovr;
    give_verdict;
  end

  // Cut a hang short
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    give_verdict;
  end
endmodule

bind fv_fader fv_fader_checker u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SCL(SCL),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SAMPLE_VALID(SAMPLE_VALID), .MAIN_IN(MAIN_IN),
  .OUT_VALID(OUT_VALID), .FADER_OUT(FADER_OUT), .ENC_OUT(ENC_OUT));
